// ==== hdl/fpec_pkg.sv ====
/*
 * Constants and types for the flash program/erase control block.
 * Assumes a single 100 MHz system clock and a plain register port.
 */
package fpec_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0]  FPEC_ADDR_CONTROL   = 4'h0;  // Operation control
   localparam logic [3:0]  FPEC_ADDR_KEY       = 4'h1;  // Unlock key, write only
   localparam logic [3:0]  FPEC_ADDR_TBLPAGE   = 4'h2;  // Table page register
   localparam logic [3:0]  FPEC_ADDR_POINTER   = 4'h3;  // Effective address
   localparam logic [3:0]  FPEC_ADDR_WLOW      = 4'h4;  // Table write low word
   localparam logic [3:0]  FPEC_ADDR_WHIGH     = 4'h5;  // Table write high byte
   localparam logic [3:0]  FPEC_ADDR_STATUS    = 4'h6;  // Block status

   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   localparam int          FPEC_BIT_START      = 15;    // Start bit
   localparam int          FPEC_BIT_OP_WRITE_ENABLE       = 14;    // Write enable
   localparam int          FPEC_BIT_ERR        = 13;    // Sequence error
   localparam int          FPEC_BIT_ERASE      = 6;     // Erase mode
   localparam int          FPEC_OP_LSB         = 0;     // Op code low bit
   localparam logic [15:0] FPEC_CONTROL_RESET  = 16'h0000;
   localparam logic [15:0] FPEC_CONTROL_MASK   = 16'hE04F; // Implemented bits

   // ---------------------------------------------------------------
   // Unlock keys
   // ---------------------------------------------------------------
   localparam logic [7:0]  FPEC_KEY_FIRST      = 8'h55;
   localparam logic [7:0]  FPEC_KEY_SECOND     = 8'hAA;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int          FPEC_ROW_WORDS      = 64;    // Instructions per row
   localparam int          FPEC_PAGE_WORDS     = 512;   // Instructions per page
   localparam int          FPEC_ROW_BYTES      = 192;
   localparam int          FPEC_PAGE_BYTES     = 1536;

   // ---------------------------------------------------------------
   // Timing in microseconds
   // ---------------------------------------------------------------
   localparam int          FPEC_CLK_MHZ        = 100;
   localparam int          FPEC_T_ROW_US       = 1500;  // Row write
   localparam int          FPEC_T_PAGE_US      = 20000; // Page erase
   localparam int          FPEC_T_WORD_US      = 50;    // Word program
   localparam int          FPEC_T_BULK_US      = 40000; // Bulk or segment erase
   localparam int          FPEC_ROW_CYC        = FPEC_T_ROW_US * FPEC_CLK_MHZ;
   localparam int          FPEC_PAGE_CYC       = FPEC_T_PAGE_US * FPEC_CLK_MHZ;
   localparam int          FPEC_WORD_CYC       = FPEC_T_WORD_US * FPEC_CLK_MHZ;
   localparam int          FPEC_BULK_CYC       = FPEC_T_BULK_US * FPEC_CLK_MHZ;

   // ---------------------------------------------------------------
   // Operation kinds
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      FPEC_OP_NONE,
      FPEC_OP_BULK,
      FPEC_OP_SEGMENT,
      FPEC_OP_PAGE,
      FPEC_OP_CFG_ERASE,
      FPEC_OP_WORD,
      FPEC_OP_ROW,
      FPEC_OP_CFG_PROG
   } fpec_op_type;

   // Request to the flash array
   typedef struct packed {
      fpec_op_type op;       // Operation
      logic [23:0] addr;     // Target address
      logic [23:0] data;     // Word data for single programs
   } fpec_req_type;

endpackage : fpec_pkg

// ==== hdl/fpec_timer.sv ====
/*
 * Down counter that times one flash cycle.
 * Assumes load is a single-cycle pulse from the sequencer.
 */
`timescale 1ns/1ps
module fpec_timer #(
   parameter int W = 24  // Counter width
) (
   input  wire logic         sys_clk,  // System clock
   input  wire logic         nrst,  // Async reset, low
   input  wire logic         load,  // Start a count
   input  wire logic [W-1:0] cycles,  // Cycles to count
   output logic              busy,  // Counting
   output logic              done  // Count expired pulse
);

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   logic [W-1:0] cnt_r;                        // Remaining cycles

   // Load and count down
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin                       // New cycle
            cnt_r <= cycles;
            busy  <= 1'b1;
         end else if (busy) begin
            if (cnt_r <= W'(1)) begin          // Last cycle
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - W'(1);
            end
         end
      end
   end

endmodule : fpec_timer

// ==== hdl/fpec_ctrl.sv ====
/*
 * Flash program/erase sequencer: control and key registers, unlock check,
 * row holding buffer, address forming and self-timed cycles.
 * Assumes nrst is the power-on reset and the register port is on sys_clk.
 */
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module fpec_ctrl #(
   parameter int ROW_CYC  = fpec_pkg::FPEC_ROW_CYC,   // Row write cycles
   parameter int PAGE_CYC = fpec_pkg::FPEC_PAGE_CYC,  // Page erase cycles
   parameter int WORD_CYC = fpec_pkg::FPEC_WORD_CYC,  // Word program cycles
   parameter int BULK_CYC = fpec_pkg::FPEC_BULK_CYC,  // Bulk erase cycles
   parameter int ROWN     = fpec_pkg::FPEC_ROW_WORDS  // Holding buffer depth
) (
   input  wire logic         sys_clk,  // System clock
   input  wire logic         nrst,  // Power-on reset, low
   input  wire logic [3:0]   regAddr,  // Register index
   input  wire logic [15:0]  regWdata,  // Write data
   input  wire logic         regWr,  // Write strobe
   input  wire logic         regRd,  // Read strobe
   output logic [15:0]       regRdata,  // Read data, next cycle
   output logic              cpuStall,  // Processor stall
   output fpec_pkg::fpec_req_type flashReq,  // Operation request
   output logic              flashStrobe,  // Request pulse
   output logic [5:0]        bufRdIdx,  // Holding buffer index
   output logic [23:0]       bufRdData  // Holding buffer word
);
   import fpec_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic        start_r;  // Start bit
   logic        op_write_enable_r;  // Write enable
   logic        err_r;  // Sequence error
   logic        erase_r;  // Erase mode
   logic [3:0]  opSel_r;  // Operation select code
   logic [7:0]  tblPage_r;  // Table page
   logic [15:0] ptr_r;  // Effective address
   logic [15:0] wLow_r;  // Last table write low
   logic [7:0]  wHigh_r;  // Last table write high
   logic [1:0]  keyState_r;  // 0 none, 1 first, 2 unlocked
   logic [23:0] holdBuf [ROWN];  // Row holding buffer
   logic [$clog2(ROWN)-1:0] fill_r;  // Buffer fill index
   logic        bufFull_r;  // All words loaded
   fpec_op_type activeOp_r;  // Running operation
   logic [15:0] ctrlView;  // Control read view
   logic [15:0] statView;  // Status read view
   logic        busy;  // Timer running
   logic        timerDone;  // Timer expired
   logic        timerLoad_r;  // Timer start pulse
   logic [31:0] timerCycles_r;  // Cycles for this op
   logic [23:0] target;  // Formed flash address

   // Write decodes
   wire wrCtrl = regWr && regAddr == FPEC_ADDR_CONTROL;
   wire wrKey  = regWr && regAddr == FPEC_ADDR_KEY;
   wire setReq = wrCtrl && regWdata[FPEC_BIT_START];

   // ---------------------------------------------------------------
   // Decode of the operation select code
   // ---------------------------------------------------------------
   function automatic fpec_op_type decodeOp(input logic er, input logic [3:0] c);
      fpec_op_type o;
      o = FPEC_OP_NONE;                        // Unlisted codes do nothing
      if (er) begin                            // Erase class
         unique case (c)
            4'hF:    o = FPEC_OP_BULK;
            4'hD:    o = FPEC_OP_SEGMENT;
            4'hC:    o = FPEC_OP_SEGMENT;
            4'h2:    o = FPEC_OP_PAGE;
            4'h0:    o = FPEC_OP_CFG_ERASE;
            default: o = FPEC_OP_NONE;
         endcase
      end else begin
         unique case (c)
            4'h3:    o = FPEC_OP_WORD;
            4'h1:    o = FPEC_OP_ROW;
            4'h0:    o = FPEC_OP_CFG_PROG;
            default: o = FPEC_OP_NONE;
         endcase
      end
      return o;
   endfunction : decodeOp

   // Cycle count for an operation
   function automatic logic [31:0] opCycles(input fpec_op_type o);
      unique case (o)
         FPEC_OP_BULK, FPEC_OP_SEGMENT: return 32'(BULK_CYC);
         FPEC_OP_PAGE:                  return 32'(PAGE_CYC);
         FPEC_OP_ROW:                   return 32'(ROW_CYC);
         default:                       return 32'(WORD_CYC);
      endcase
   endfunction : opCycles

   wire fpec_op_type reqOp = decodeOp(regWdata[FPEC_BIT_ERASE], regWdata[3:0]);

   // Start is accepted only unlocked, enabled, idle and decodable
   wire startOk = setReq && keyState_r == 2'd2 && regWdata[FPEC_BIT_OP_WRITE_ENABLE]
                  && !start_r && reqOp != FPEC_OP_NONE
                  && !(reqOp == FPEC_OP_ROW && !bufFull_r);

   // Address from table page over effective address
   assign target = {tblPage_r, ptr_r};

   // ---------------------------------------------------------------
   // Unlock key tracking
   // ---------------------------------------------------------------
   // Any write other than the expected next step drops the unlock
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         keyState_r <= 2'd0;
      end else if (wrKey && regWdata[7:0] == FPEC_KEY_FIRST) begin
         keyState_r <= 2'd1;
      end else if (wrKey && keyState_r == 2'd1 && regWdata[7:0] == FPEC_KEY_SECOND) begin
         keyState_r <= 2'd2;
      end else if (regWr) begin
         keyState_r <= 2'd0;
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   // Start clears when the timer expires; error clears on a good start or a written zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         start_r <= FPEC_CONTROL_RESET[FPEC_BIT_START];
         op_write_enable_r  <= FPEC_CONTROL_RESET[FPEC_BIT_OP_WRITE_ENABLE];
         err_r   <= FPEC_CONTROL_RESET[FPEC_BIT_ERR];
         erase_r <= FPEC_CONTROL_RESET[FPEC_BIT_ERASE];
         opSel_r <= FPEC_CONTROL_RESET[3:0];
      end else begin
         if (wrCtrl && !start_r) begin         // Fields frozen while running
            op_write_enable_r  <= regWdata[FPEC_BIT_OP_WRITE_ENABLE];
            erase_r <= regWdata[FPEC_BIT_ERASE];
            opSel_r <= regWdata[3:0];
         end
         if (startOk) begin
            start_r <= 1'b1;
         end else if (timerDone) begin
            start_r <= 1'b0;
         end
         if (setReq && !start_r && !startOk) begin
            err_r <= 1'b1;
         end else if (startOk) begin
            err_r <= 1'b0;
         end else if (wrCtrl && !regWdata[FPEC_BIT_ERR]) begin
            err_r <= 1'b0;                     // Software clear
         end
      end
   end

   // ---------------------------------------------------------------
   // Table page, pointer and table write capture
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tblPage_r <= 8'h00;
         ptr_r     <= 16'h0000;
         wLow_r    <= 16'h0000;
         wHigh_r   <= 8'h00;
      end else if (regWr) begin
         if (regAddr == FPEC_ADDR_TBLPAGE) tblPage_r <= regWdata[7:0];
         if (regAddr == FPEC_ADDR_POINTER) ptr_r     <= regWdata;
         if (regAddr == FPEC_ADDR_WLOW)    wLow_r    <= regWdata;
         if (regAddr == FPEC_ADDR_WHIGH)   wHigh_r   <= regWdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Holding buffer: high byte write completes a word
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fill_r    <= '0;
         bufFull_r <= 1'b0;
      end else if (regWr && regAddr == FPEC_ADDR_POINTER) begin
         fill_r    <= '0;                      // New aligned group
         bufFull_r <= 1'b0;
      end else if (regWr && regAddr == FPEC_ADDR_WHIGH) begin
         fill_r <= fill_r + 1'b1;              // Sequential load
         if (fill_r == ($clog2(ROWN))'(ROWN - 1)) bufFull_r <= 1'b1;
      end else if (timerDone && activeOp_r == FPEC_OP_ROW) begin
         bufFull_r <= 1'b0;
      end
   end

   // Buffer storage
   always_ff @(posedge sys_clk) begin
      if (regWr && regAddr == FPEC_ADDR_WHIGH) begin
         holdBuf[fill_r] <= {regWdata[7:0], wLow_r};
      end
   end

   // ---------------------------------------------------------------
   // Launch and flash request
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         activeOp_r    <= FPEC_OP_NONE;
         timerLoad_r   <= 1'b0;
         timerCycles_r <= 32'h0000_0000;
         flashStrobe   <= 1'b0;
         flashReq      <= '0;
      end else begin
         timerLoad_r <= startOk;
         flashStrobe <= startOk;
         if (startOk) begin
            activeOp_r      <= reqOp;
            timerCycles_r   <= opCycles(reqOp);
            flashReq.op     <= reqOp;
            flashReq.data   <= {wHigh_r, wLow_r};
            unique case (reqOp)                // Page and row aligned from memory start
               FPEC_OP_PAGE: flashReq.addr <= target - (target % 24'(FPEC_PAGE_WORDS * 2));
               FPEC_OP_ROW:  flashReq.addr <= target - (target % 24'(FPEC_ROW_WORDS * 2));
               default:      flashReq.addr <= target;
            endcase
         end
      end
   end

   // Self-timed flash cycle
   fpec_timer #(.W(32)) u_timer (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .load    (timerLoad_r),
      .cycles  (timerCycles_r),
      .busy    (busy),
      .done    (timerDone)
   );

   // Processor stall for the whole cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cpuStall <= 1'b0;
      end else begin
         cpuStall <= startOk || (start_r && !timerDone);
      end
   end

   // Buffer read port for the array, walks while a row is written
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bufRdIdx  <= 6'h00;
         bufRdData <= 24'h000000;
      end else if (busy && activeOp_r == FPEC_OP_ROW) begin
         bufRdIdx  <= bufRdIdx + 6'h01;
         bufRdData <= holdBuf[bufRdIdx[$clog2(ROWN)-1:0]];
      end else begin
         bufRdIdx  <= 6'h00;
      end
   end

   // ---------------------------------------------------------------
   // Read mux; key and unimplemented bits read zero
   // ---------------------------------------------------------------
   always_comb begin
      ctrlView = 16'h0000;
      ctrlView[FPEC_BIT_START] = start_r;
      ctrlView[FPEC_BIT_OP_WRITE_ENABLE]  = op_write_enable_r;
      ctrlView[FPEC_BIT_ERR]   = err_r;
      ctrlView[FPEC_BIT_ERASE] = erase_r;
      ctrlView[3:0]            = opSel_r;
      ctrlView = ctrlView & FPEC_CONTROL_MASK;
      statView = 16'({bufFull_r, fill_r, keyState_r == 2'd2});
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         unique case (regAddr)
            FPEC_ADDR_CONTROL: regRdata <= ctrlView;
            FPEC_ADDR_TBLPAGE: regRdata <= {8'h00, tblPage_r};
            FPEC_ADDR_POINTER: regRdata <= ptr_r;
            FPEC_ADDR_STATUS:  regRdata <= statView;
            default:           regRdata <= 16'h0000;  // Key, table write and unmapped
         endcase
      end else begin
         regRdata <= 16'h0000;
      end
   end

endmodule : fpec_ctrl

// ==== dv/fpec_ctrl_props.sv ====
/* Port checker for the flash program/erase sequencer.
   Sees only fpec_ctrl ports; bound to it at the foot of this file. */
`timescale 1ns/1ps
module fpec_ctrl_props
   import fpec_pkg::*;
#(
   parameter int WORD_CYC = 20,  // Shortest flash cycle
   parameter int BULK_CYC = 40  // Longest flash cycle
) (
   input wire logic                   sys_clk,     // System clock
   input wire logic                   nrst,        // Power-on reset, low
   input wire logic [3:0]             regAddr,     // Register index
   input wire logic [15:0]            regWdata,    // Write data
   input wire logic                   regWr,       // Write strobe
   input wire logic                   regRd,       // Read strobe
   input wire logic [15:0]            regRdata,    // Read data
   input wire logic                   cpuStall,    // Processor stall
   input wire fpec_pkg::fpec_req_type flashReq,    // Operation request
   input wire logic                   flashStrobe  // Request pulse
);
   // ---------------------------------------------------------------
   // Helpers: last two writes and stall length
   // ---------------------------------------------------------------
   logic [11:0] w1_r;  // Newest write
   logic [11:0] w2_r;  // Write before that
   logic [15:0] stallCnt_r;  // Cycles stalled so far
   logic        keyOk;  // Both keys just written
   assign keyOk = (w1_r == {FPEC_ADDR_KEY, FPEC_KEY_SECOND}) && (w2_r == {FPEC_ADDR_KEY, FPEC_KEY_FIRST});
   // Shift in address and key byte of each write
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         w1_r <= 12'h000;
         w2_r <= 12'h000;
      end else if (regWr) begin
         w1_r <= {regAddr, regWdata[7:0]};
         w2_r <= w1_r;
      end
   end
   // Count stalled cycles, clear when released
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) stallCnt_r <= 16'h0000;
      else stallCnt_r <= cpuStall ? stallCnt_r + 16'h0001 : 16'h0000;
   end
   // Operation expected from erase bit and select code
   function automatic fpec_op_type exp_op(input logic er, input logic [3:0] c);
      return er ? (c == 4'hF ? FPEC_OP_BULK : (c == 4'hD || c == 4'hC) ? FPEC_OP_SEGMENT : c == 4'h2 ? FPEC_OP_PAGE
                   : c == 4'h0 ? FPEC_OP_CFG_ERASE : FPEC_OP_NONE)
                : (c == 4'h3 ? FPEC_OP_WORD : c == 4'h1 ? FPEC_OP_ROW : c == 4'h0 ? FPEC_OP_CFG_PROG : FPEC_OP_NONE);
   endfunction : exp_op
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   strobe_pulse_a:  assert property (flashStrobe |=> !flashStrobe) else $error("strobe longer than one cycle");
   strobe_stall_a:  assert property (flashStrobe |-> cpuStall) else $error("no stall with start");
   start_cause_a:   assert property (flashStrobe |-> $past(regWr && regAddr == FPEC_ADDR_CONTROL && regWdata[15]
                       && regWdata[14])) else $error("start without enabled start write");
   unlock_seen_a:   assert property (flashStrobe |-> $past(keyOk)) else $error("start without fresh unlock");
   idle_start_a:    assert property (flashStrobe |-> !$past(cpuStall)) else $error("start while busy");
   op_decode_a:     assert property (flashStrobe |-> flashReq.op == exp_op($past(regWdata[6]), $past(regWdata[3:0]))
                       && flashReq.op != FPEC_OP_NONE) else $error("wrong operation decoded");
   rd_idle_a:       assert property (!regRd |=> regRdata == 16'h0000) else $error("read data without read");
   key_hidden_a:    assert property (regRd && regAddr == FPEC_ADDR_KEY |=> regRdata == 16'h0000)
                       else $error("key readable");
   ctrl_unimpl_a:   assert property (regRd && regAddr == FPEC_ADDR_CONTROL |=> (regRdata & ~FPEC_CONTROL_MASK) == 16'h0000)
                       else $error("unimplemented control bits set");
   stall_min_a:     assert property ($fell(cpuStall) |-> stallCnt_r >= WORD_CYC) else $error("stall too short");
   stall_max_a:     assert property (cpuStall |-> stallCnt_r <= BULK_CYC + 4) else $error("stall too long");
   page_cov:        cover property (flashStrobe && flashReq.op == FPEC_OP_PAGE);
   row_cov:         cover property (flashStrobe && flashReq.op == FPEC_OP_ROW);
   done_cov:        cover property ($fell(cpuStall));
endmodule : fpec_ctrl_props
bind fpec_ctrl fpec_ctrl_props #(.WORD_CYC(WORD_CYC), .BULK_CYC(BULK_CYC)) u_props (.sys_clk(sys_clk), .nrst(nrst),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuStall(cpuStall),
   .flashReq(flashReq), .flashStrobe(flashStrobe));

// ==== dv/fpec_cpu_model.sv ====
/* Processor-side model: register bus master and start software sequence.
   Tasks are entered just after a rising edge of sys_clk. */
`timescale 1ns/1ps
module fpec_cpu_model
   import fpec_pkg::*;
(
   input  wire logic        sys_clk,    // System clock
   input  wire logic        cpuStall,   // Stall from the block
   input  wire logic [15:0] regRdata,   // Read data
   output logic [3:0]       regAddr,    // Register index
   output logic [15:0]      regWdata,   // Write data
   output logic             regWr,      // Write strobe
   output logic             regRd       // Read strobe
);
   // Idle bus at time zero
   initial begin
      regAddr = 4'h0;
      regWdata = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   // One write cycle; strobe held for a following write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      regAddr <= a;
      regWdata <= d;
      regRd <= 1'b0;
      regWr <= 1'b1;
      @(posedge sys_clk);
   endtask : wr
   // One idle cycle
   task automatic idle();
      regWr <= 1'b0;
      regRd <= 1'b0;
      @(posedge sys_clk);
   endtask : idle
   // Read; data taken in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      regAddr <= a;
      regWr <= 1'b0;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
      @(posedge sys_clk);
   endtask : rd
   // Two key writes back to back
   task automatic unlock();
      wr(FPEC_ADDR_KEY, 16'h0055);
      wr(FPEC_ADDR_KEY, 16'h00AA);
   endtask : unlock
   // Wait out the flash cycle, bounded
   task automatic wait_idle();
      for (int n = 0; n < 500 && cpuStall !== 1'b0; n++) begin
         @(posedge sys_clk);
         #1;
      end
   endtask : wait_idle
   // Full start sequence: keys, start write, two no-ops, wait
   task automatic launch(input logic [15:0] ctrl);
      unlock();
      wr(FPEC_ADDR_CONTROL, ctrl);
      idle();
      idle();
      #1 wait_idle();
   endtask : launch
endmodule : fpec_cpu_model

// ==== dv/tb_fpec_ctrl.sv ====
/* Self-checking bench for fpec_ctrl with shortened flash cycles.
   Drives the register port through fpec_cpu_model. */
`timescale 1ns/1ps
module tb_fpec_ctrl;
   import fpec_pkg::*;
   logic         sys_clk, nrst, regWr, regRd, cpuStall, flashStrobe;  // Clock, reset, strobes
   logic [3:0]   regAddr;  // Register index
   logic [15:0]  regWdata, regRdata, rdv;  // Bus data
   logic [5:0]   bufRdIdx;  // Buffer walk index
   logic [23:0]  bufRdData, lastAddr;  // Buffer word, seen address
   fpec_req_type flashReq;  // Request
   fpec_op_type  lastOp, eo;  // Seen and expected op
   int           miscompares, comparisons, strobes, cycles, n0;  // Counters
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   fpec_ctrl #(.ROW_CYC(24), .PAGE_CYC(30), .WORD_CYC(20), .BULK_CYC(40)) u_dut (.sys_clk(sys_clk),
      .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .cpuStall(cpuStall), .flashReq(flashReq), .flashStrobe(flashStrobe), .bufRdIdx(bufRdIdx), .bufRdData(bufRdData));
   fpec_cpu_model u_cpu (.sys_clk(sys_clk), .cpuStall(cpuStall), .regRdata(regRdata), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd));
   // Record requests mid-cycle; cut a hang short
   always @(negedge sys_clk) begin
      cycles++;
      if (flashStrobe === 1'b1) begin
         strobes++;
         lastOp = flashReq.op;
         lastAddr = flashReq.addr;
      end
      if (bufRdIdx != 6'h00) chk("buffer", {2'b00, bufRdIdx - 6'h01, 10'h000, bufRdIdx - 6'h01}, bufRdData);
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
      u_cpu.rd(a, rdv);
      chk("register", {8'h00, e}, {8'h00, rdv});
   endtask : rdchk
   // Reset values, hidden key, unmapped index, unimplemented bits
   task automatic t_regs();
      rdchk(FPEC_ADDR_CONTROL, 16'h0000);
      u_cpu.wr(FPEC_ADDR_KEY, 16'h1255);
      rdchk(FPEC_ADDR_KEY, 16'h0000);
      rdchk(4'hF, 16'h0000);
      u_cpu.wr(FPEC_ADDR_CONTROL, 16'h5FBF);
      rdchk(FPEC_ADDR_CONTROL, 16'h400F);
   endtask : t_regs
   // Every erase and program code, erase class first
   task automatic t_codes();
      u_cpu.wr(FPEC_ADDR_TBLPAGE, 16'h0012);
      u_cpu.wr(FPEC_ADDR_POINTER, 16'h3456);
      for (int k = 31; k >= 0; k--) begin
         eo = u_dut.u_props.exp_op(k[4], k[3:0]);
         if (eo == FPEC_OP_ROW) begin
            u_cpu.wr(FPEC_ADDR_POINTER, 16'h3400);
            for (int i = 0; i < 64; i++) begin
               u_cpu.wr(FPEC_ADDR_WLOW, 16'(i));
               u_cpu.wr(FPEC_ADDR_WHIGH, 16'(i));
            end
         end
         n0 = strobes;
         u_cpu.launch(16'hC000 | {9'h000, k[4], 2'b00, k[3:0]});
         chk("strobes", 24'(n0 + (eo != FPEC_OP_NONE)), 24'(strobes));
         if (eo != FPEC_OP_NONE) chk("op", 24'(eo), 24'(lastOp));
         if (eo == FPEC_OP_PAGE) chk("address", 24'h123400, lastAddr);
         rdchk(FPEC_ADDR_CONTROL, (eo == FPEC_OP_NONE ? 16'h6000 : 16'h4000) | {9'h000, k[4], 2'b00, k[3:0]});
      end
   endtask : t_codes
   // Refusals: no enable, no keys, broken unlocks
   task automatic t_refuse();
      n0 = strobes;
      u_cpu.launch(16'h8042);
      rdchk(FPEC_ADDR_CONTROL, 16'h2042);
      u_cpu.wr(FPEC_ADDR_CONTROL, 16'hC042);
      u_cpu.wr(FPEC_ADDR_KEY, 16'h0055);
      u_cpu.wr(FPEC_ADDR_TBLPAGE, 16'h0012);
      u_cpu.wr(FPEC_ADDR_KEY, 16'h00AA);
      u_cpu.wr(FPEC_ADDR_CONTROL, 16'hC042);
      u_cpu.unlock();
      u_cpu.wr(FPEC_ADDR_TBLPAGE, 16'h0012);
      u_cpu.wr(FPEC_ADDR_CONTROL, 16'hC042);
      u_cpu.idle();
      chk("strobes", 24'(n0), 24'(strobes));
      rdchk(FPEC_ADDR_CONTROL, 16'h6042);
   endtask : t_refuse
   // Software clear ignored while busy; hardware clears; power-on reset mid-cycle
   task automatic t_busy();
      u_cpu.unlock();
      u_cpu.wr(FPEC_ADDR_CONTROL, 16'hC042);
      u_cpu.wr(FPEC_ADDR_CONTROL, 16'h4000);
      rdchk(FPEC_ADDR_CONTROL, 16'hC042);
      u_cpu.wait_idle();
      rdchk(FPEC_ADDR_CONTROL, 16'h4042);
      u_cpu.unlock();
      u_cpu.wr(FPEC_ADDR_CONTROL, 16'hC04F);
      u_cpu.idle();
      nrst <= 1'b0;
      @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      chk("stall", 24'h000000, {23'h0, cpuStall});
      rdchk(FPEC_ADDR_CONTROL, 16'h0000);
   endtask : t_busy
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   // Main sequence
   initial begin
      nrst = 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_codes();
      t_refuse();
      t_busy();
      final_report();
   end
endmodule : tb_fpec_ctrl
